// ### common/cdr_pkg.sv
// Package for the clock-recovery status and squelch control block.
// Assumes a single 25 MHz system clock; all pins are sampled into it.
package cdr_pkg;
    // Reference presence: a run of toggles on the reference input
    localparam int unsigned REF_WIN = 16;
    localparam int unsigned REF_MIN_TOGGLES = 4;
    // Frequency compare window, in system clock cycles
    localparam int unsigned FREQ_WIN = 64;
    // Allowed difference of edge counts between recovered and reference clocks
    localparam logic [7:0] FREQ_TOL = 8'h02;
    // Default bit period minus one, in system clock cycles
    localparam logic [3:0] BIT_PERIOD = 4'h3;
    // Loop lock: consecutive in-phase data edges to declare lock
    localparam logic [7:0] LOCK_RUN = 8'h08;
    // Reset values of the active-low status outputs
    localparam logic LOCK_LOST_N_RST = 1'b0;
    localparam logic SIGNAL_LOST_N_RST = 1'b0;
    // Threshold width of the loss-of-signal level control
    localparam int unsigned AMP_W = 8;

    typedef enum logic [1:0] {
        CDR_TRACK = 2'b00,
        CDR_HOLD = 2'b01,
        CDR_REF = 2'b11
    } cdr_mode_t;
endpackage

// ### design/cdr_status_squelch.sv
// Status, reference forcing and data squelch for a clock-and-data recovery receiver.
// Assumes the sliced serial data, reference, force-lock and mute pins arrive asynchronous to clk.
//
// Overview of operation
// - Present reference sets loop center frequency
// - Lock lost when recovered frequency leaves reference
// - Referenceless: lock lost when loop unlocks while tracking; held when forced
// - Force-lock low: ignore serial data for tracking
// - Force-lock low with reference: follow reference
// - Force-lock low without reference: freeze loop
// - Signal lost when amplitude below threshold
// - Mute forces output zero: true 0, complement 1
// - Recover clock and data from serial input
// - Output data retimed by recovered clock
// - Clock from data unless forced, whatever the lock state
`timescale 1ns/10ps
module cdr_status_squelch
    import cdr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_data_in,
    input wire logic ref_clock_in,
    input wire logic force_ref_lock_n,
    input wire logic data_mute,
    input wire logic [AMP_W-1:0] signal_amplitude,
    input wire logic [AMP_W-1:0] signal_loss_threshold,
    output logic data_out_p,
    output logic data_out_n,
    output logic recovered_clk_out,
    output logic lock_lost_n,
    output logic signal_lost_n,
    output logic ref_present,
    output cdr_mode_t loop_mode
);
    // ==========================================================
    // Input synchronisers
    logic [1:0] din_s, ref_s, frc_s, mute_s;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            din_s <= 2'h0;
            ref_s <= 2'h3;
            frc_s <= 2'h3;
            mute_s <= 2'h0;
        end else begin
            din_s <= {din_s[0], serial_data_in};
            ref_s <= {ref_s[0], ref_clock_in};
            frc_s <= {frc_s[0], force_ref_lock_n};
            mute_s <= {mute_s[0], data_mute};
        end
    end
    logic din, refc, forced, mute;
    assign din = din_s[1];
    assign refc = ref_s[1];
    assign forced = !frc_s[1];
    assign mute = mute_s[1];

    logic din_d, ref_d;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            din_d <= 1'b0;
            ref_d <= 1'b1;
        end else begin
            din_d <= din;
            ref_d <= refc;
        end
    end
    logic din_edge, ref_edge;
    assign din_edge = din ^ din_d;
    assign ref_edge = refc ^ ref_d;
    // Frequency and phase follow one edge per reference period
    logic ref_rise;
    assign ref_rise = refc && !ref_d;

    // ==========================================================
    // Reference detection: a reference tied static reads as absent
    logic [4:0] rwin_cnt, rtog_cnt;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rwin_cnt <= 5'h00;
            rtog_cnt <= 5'h00;
            ref_present <= 1'b0;
        end else if (rwin_cnt == 5'(REF_WIN - 1)) begin
            rwin_cnt <= 5'h00;
            rtog_cnt <= 5'h00;
            ref_present <= (rtog_cnt >= 5'(REF_MIN_TOGGLES));
        end else begin
            rwin_cnt <= rwin_cnt + 5'h01;
            if (ref_edge && rtog_cnt != 5'h1f) begin
                rtog_cnt <= rtog_cnt + 5'h01;
            end
        end
    end

    // ==========================================================
    // Loop mode
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            loop_mode <= CDR_TRACK;
        end else if (forced && ref_present) begin
            loop_mode <= CDR_REF;
        end else if (forced) begin
            loop_mode <= CDR_HOLD;
        end else begin
            loop_mode <= CDR_TRACK;
        end
    end

    // ==========================================================
    // Recovery loop: bit clock follows data edges while tracking
    // Period is frozen while holding, phase free-runs; data edges unused when forced.
    logic [3:0] phase;
    logic [3:0] period;
    logic [3:0] since_edge;
    logic bit_tick;
    assign bit_tick = (phase == period);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase <= 4'h0;
            since_edge <= 4'h0;
            period <= BIT_PERIOD;
        end else begin
            case (loop_mode)
                CDR_TRACK: begin
                    if (din_edge) begin
                        phase <= 4'h0;
                        since_edge <= 4'h0;
                        if (!ref_present && since_edge != 4'h0) begin
                            period <= since_edge;
                        end
                    end else begin
                        phase <= bit_tick ? 4'h0 : phase + 4'h1;
                        since_edge <= since_edge + 4'h1;
                    end
                end
                CDR_REF: begin
                    // Data ignored, timing taken from the reference
                    phase <= ref_rise ? 4'h0 : (bit_tick ? 4'h0 : phase + 4'h1);
                end
                CDR_HOLD: begin
                    phase <= bit_tick ? 4'h0 : phase + 4'h1;
                end
                default: phase <= 4'h0;
            endcase
            if (ref_present && ref_rise) begin
                period <= BIT_PERIOD;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            recovered_clk_out <= 1'b0;
        end else begin
            recovered_clk_out <= (phase < {1'b0, period[3:1]});
        end
    end

    // ==========================================================
    // Retiming and squelch on the output stage
    logic retimed;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            retimed <= 1'b0;
        end else if (bit_tick) begin
            retimed <= din;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_out_p <= 1'b0;
            data_out_n <= 1'b1;
        end else if (bit_tick) begin
            data_out_p <= mute ? 1'b0 : retimed;
            data_out_n <= mute ? 1'b1 : !retimed;
        end
    end

    // ==========================================================
    // Lock detect
    logic [6:0] fwin;
    logic [7:0] rec_cnt, ref_cnt;
    logic [7:0] run_cnt;
    logic freq_bad;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fwin <= 7'h00;
            rec_cnt <= 8'h00;
            ref_cnt <= 8'h00;
            freq_bad <= 1'b0;
        end else if (fwin == 7'(FREQ_WIN - 1)) begin
            fwin <= 7'h00;
            rec_cnt <= 8'h00;
            ref_cnt <= 8'h00;
            freq_bad <= (rec_cnt > ref_cnt + FREQ_TOL) ||
                        (ref_cnt > rec_cnt + FREQ_TOL);
        end else begin
            fwin <= fwin + 7'h01;
            rec_cnt <= rec_cnt + {7'h00, bit_tick};
            ref_cnt <= ref_cnt + {7'h00, ref_rise};
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_cnt <= 8'h00;
        end else if (din_edge && since_edge != period && since_edge != 4'h0) begin
            run_cnt <= 8'h00;
        end else if (din_edge && run_cnt != LOCK_RUN) begin
            run_cnt <= run_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lock_lost_n <= LOCK_LOST_N_RST;
        end else if (ref_present) begin
            lock_lost_n <= !freq_bad;
        end else if (loop_mode == CDR_TRACK) begin
            lock_lost_n <= (run_cnt == LOCK_RUN);
        end
    end

    // ==========================================================
    // Loss of signal; amplitude arrives as a settled level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            signal_lost_n <= SIGNAL_LOST_N_RST;
        end else begin
            signal_lost_n <= !(signal_amplitude < signal_loss_threshold);
        end
    end

    // ==========================================================
    // Checks
    AST_SQUELCH_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        $past(mute) && $past(bit_tick) |-> !data_out_p && data_out_n)
        else $error("muted output not zero");
    AST_LEGS_OPPOSITE: assert property (@(posedge clk) disable iff (!rst_b)
        data_out_p != data_out_n) else $error("output legs not complementary");
    AST_PASS_DATA: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(mute) && $past(bit_tick) |-> data_out_p == $past(retimed))
        else $error("retimed data not passed");
    AST_SIGNAL_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
        signal_amplitude < signal_loss_threshold |=> !signal_lost_n)
        else $error("signal loss not flagged");
    AST_HOLD_MODE: assert property (@(posedge clk) disable iff (!rst_b)
        forced && !ref_present |=> loop_mode == CDR_HOLD)
        else $error("loop not frozen");
    AST_REF_MODE: assert property (@(posedge clk) disable iff (!rst_b)
        forced && ref_present |=> loop_mode == CDR_REF)
        else $error("loop not on reference");
    AST_HOLD_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
        loop_mode == CDR_HOLD && !ref_present |=> $stable(period))
        else $error("period moved while frozen");
    AST_FREQ_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
        ref_present && freq_bad |=> !lock_lost_n)
        else $error("frequency loss not flagged");
    AST_LOOP_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
        !ref_present && loop_mode == CDR_TRACK && run_cnt != LOCK_RUN |=> !lock_lost_n)
        else $error("loop unlock not flagged");

    COV_MUTE: cover property (@(posedge clk) disable iff (!rst_b) mute && bit_tick);
    COV_REF: cover property (@(posedge clk) disable iff (!rst_b) loop_mode == CDR_REF);
    COV_HOLD: cover property (@(posedge clk) disable iff (!rst_b) loop_mode == CDR_HOLD);
    COV_LOCK: cover property (@(posedge clk) disable iff (!rst_b) $rose(lock_lost_n));
endmodule

// ### verification/cdr_line_model.sv
// Far-side model: optical front end feeding line data and the optional reference.
// Assumes the bench clock; both lines change on its falling edge only.
`timescale 1ns/10ps
module cdr_line_model (
    input wire logic clk,
    input wire logic ref_on,
    input wire logic data_on,
    output logic serial_data_in,
    output logic ref_clock_in
);
    // ==========================================================
    // Line patterns
    logic [1:0] phase = 2'h0;
    logic data_q = 1'b0;
    logic ref_q = 1'b1;

    assign serial_data_in = data_q;
    assign ref_clock_in = ref_q;

    // Reference toggles every two cycles, data every four: one bit per default period
    always @(negedge clk) begin
        phase <= phase + 2'h1;
        if (ref_on) begin
            ref_q <= phase[1];
        end else begin
            ref_q <= 1'b1;
        end
        if (data_on && phase == 2'h3) begin
            data_q <= ~data_q;
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the status and squelch block.
// Assumes the package constants and a 25 MHz clock; inputs move on the falling edge.
`timescale 1ns/10ps
module testbench;
    import cdr_pkg::*;
    typedef struct {int sel; logic [1:0] exp;} cdr_note_t;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic force_ref_lock_n = 1'b1;
    logic data_mute = 1'b0;
    logic [AMP_W-1:0] amp = 8'h00;
    logic [AMP_W-1:0] thr = 8'h00;
    logic ref_on = 1'b0;
    logic data_on = 1'b0;
    logic serial_data_in, ref_clock_in, data_out_p, data_out_n;
    logic recovered_clk_out, lock_lost_n, signal_lost_n, ref_present;
    cdr_mode_t loop_mode;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int ones = 0;
    int rises = 0;
    logic prev_rc = 1'b0;
    logic [31:0] lfsr = 32'hf0d1;
    cdr_note_t notes[$];
    event chk_ev;
    string names[8] = '{"data_out", "lock_lost_n", "signal_lost_n", "ref_present",
        "loop_mode", "data_legs", "data_ones", "clock_rises"};

    always #20 clk = ~clk;

    cdr_line_model cdr_line_model_i (.clk(clk), .ref_on(ref_on), .data_on(data_on),
        .serial_data_in(serial_data_in), .ref_clock_in(ref_clock_in));

    cdr_status_squelch cdr_status_squelch_i (.clk(clk), .rst_b(rst_b),
        .serial_data_in(serial_data_in), .ref_clock_in(ref_clock_in),
        .force_ref_lock_n(force_ref_lock_n), .data_mute(data_mute),
        .signal_amplitude(amp), .signal_loss_threshold(thr), .data_out_p(data_out_p),
        .data_out_n(data_out_n), .recovered_clk_out(recovered_clk_out),
        .lock_lost_n(lock_lost_n), .signal_lost_n(signal_lost_n),
        .ref_present(ref_present), .loop_mode(loop_mode));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] cdr_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic note(input int sel, input logic [1:0] exp);
        notes.push_back('{sel, exp});
        ->chk_ev;
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Output watcher: drains the notes in order
    always @(chk_ev) begin
        cdr_note_t n;
        logic [1:0] seen;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.sel)
                0: seen = {data_out_p, data_out_n};
                1: seen = {1'b0, lock_lost_n};
                2: seen = {1'b0, signal_lost_n};
                3: seen = {1'b0, ref_present};
                4: seen = loop_mode;
                6: seen = {1'b0, ones == 4};
                7: seen = {1'b0, rises == 2};
                default: seen = {data_out_p ^ data_out_n, 1'b0};
            endcase
            compares++;
            if (seen !== n.exp) begin
                n_mismatch++;
                $display("wrong value %s expected %h seen %h", names[n.sel], n.exp, seen);
            end
        end
    end

    // Hang guard: the sequence needs well under 500 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        step(19);
        note(0, 2'b01);
        note(1, 2'b00);
        note(2, 2'b00);
        note(3, 2'b00);
        note(4, CDR_TRACK);
        step(1);
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            lfsr = cdr_lfsr(lfsr);
            amp = lfsr[7:0];
            thr = (i == 0) ? lfsr[7:0] : lfsr[15:8];
            data_mute = (amp < thr);
            step(3);
            note(2, {1'b0, !(amp < thr)});
        end
        data_mute = 1'b0;
        step(40);
        note(3, 2'b00);
        note(1, 2'b00);
        force_ref_lock_n = 1'b0;
        step(5);
        note(4, CDR_HOLD);
        note(1, 2'b00);
        force_ref_lock_n = 1'b1;
        step(5);
        note(4, CDR_TRACK);
        // Referenceless lock needs eight evenly spaced data edges
        data_on = 1'b1;
        step(60);
        note(1, 2'b01);
        ref_on = 1'b1;
        step(40);
        note(3, 2'b01);
        // Two full frequency windows before the compare is trusted
        step(140);
        note(1, 2'b01);
        force_ref_lock_n = 1'b0;
        step(5);
        note(4, CDR_REF);
        force_ref_lock_n = 1'b1;
        data_on = 1'b1;
        step(20);
        // Mute must land within one bit period plus the sync delay
        data_mute = 1'b1;
        step(8);
        for (int i = 0; i < 6; i++) begin
            note(0, 2'b01);
            step(1);
        end
        data_mute = 1'b0;
        step(7);
        prev_rc = recovered_clk_out;
        step(1);
        // Alternating line bits: four ones and two clock rises in any eight cycles
        for (int i = 0; i < 8; i++) begin
            note(5, 2'b10);
            ones += int'(data_out_p);
            rises += int'(recovered_clk_out && !prev_rc);
            prev_rc = recovered_clk_out;
            step(1);
        end
        note(6, 2'b01);
        note(7, 2'b01);
        step(1);
        test_done();
    end
endmodule
